// [shared/supervisor_defines.vh]
// Constants for the supervisor input filter and output select block.
`ifndef SUPERVISOR_DEFINES_VH
`define SUPERVISOR_DEFINES_VH
`define CLK_MHZ 250
`define FILT_MAX_US 100
`define FILT_MAX_CYC (`FILT_MAX_US * `CLK_MHZ)
`define CNT_W 15
`define PCLK_KHZ 100
`define PCLK_HALF_CYC ((`CLK_MHZ * 1000) / (2 * `PCLK_KHZ))
`define PCLK_W 11
`define N_DET 10
`define N_DUAL 5
`define N_OUT 10
`define N_PUMP 6
`define SRC_SEQ 2'h0
`define SRC_BUS 2'h1
`define SRC_CLK 2'h2
`define DRV_OD 3'h0
`define DRV_WEAK_VDD 3'h1
`define DRV_STRONG_VDD 3'h2
`define DRV_WEAK_VP 3'h3
`define DRV_STRONG_VP 3'h4
`define DRV_PULLDOWN 3'h5
`define DRV_PUMP 3'h6
`define A_FILT_BASE 8'h00
`define A_EDGE_BASE 8'h10
`define A_OUTCFG_BASE 8'h20
`define A_DUAL_MODE 8'h30
`define A_EDGE_SEL 8'h31
`define A_PULLDN 8'h32
`define A_BUS_DATA 8'h33
`define A_CFG_DONE 8'h34
`define A_DET_STAT 8'h40
`define A_WARN_STAT 8'h41
`define A_DIG_STAT 8'h42
`define OC_SRC_LO 0
`define OC_SRC_HI 1
`define OC_DRV_LO 2
`define OC_DRV_HI 4
`endif

// [src/supervisor_input_filter_output_select.v]
// Glitch filters, dual-function input conditioning and driver output selection.
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`include "supervisor_defines.vh"
module supervisor_input_filter_output_select #(
	parameter N_DET = `N_DET,
	parameter N_DUAL = `N_DUAL,
	parameter N_OUT = `N_OUT,
	parameter CNT_W = `CNT_W
) (
	// Clock and reset.
	input wire clk,
	input wire reset_n,
	// Raw comparator results: 0-4 are dedicated inputs, 5-9 are dual inputs analog side.
	input wire [N_DET-1:0] det_raw,
	// Digital level of each dual-function pin.
	input wire [N_DUAL-1:0] dual_function_input_pin,
	// Sequencing engine interface.
	input wire [N_OUT-1:0] seq_drive,
	output reg [N_DET-1:0] det_filtered_r,
	output reg [N_DUAL-1:0] warn_r,
	output reg warn_any_r,
	output reg [N_DUAL-1:0] dig_out_r,
	// Register port.
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata_r,
	// Driver outputs and pin controls.
	output reg [N_OUT-1:0] driver_output_r,
	output reg [N_OUT*3-1:0] driver_mode_r,
	output reg [N_OUT-1:0] driver_weak_pd_r,
	output reg [N_DUAL-1:0] pulldown_en_r
);

	// Configuration registers, all zero after reset.
	reg [CNT_W-1:0] filt_cfg_r [0:N_DET-1];
	reg [CNT_W-1:0] edge_cfg_r [0:N_DUAL-1];
	reg [`OC_DRV_HI:0] oc_cfg_r [0:N_OUT-1];
	reg [N_DUAL-1:0] dual_digital_r;
	reg [N_DUAL-1:0] edge_sel_r;
	reg [N_DUAL-1:0] pulldn_r;
	reg [N_OUT-1:0] bus_data_r;
	reg cfg_done_r;
	reg [N_DUAL-1:0] pin_s1_r;
	reg [N_DUAL-1:0] pin_s2_r;
	reg [`PCLK_W-1:0] pclk_cnt_r;
	reg pclk_r;

	// Longest timeout in clock cycles, kept at full width so that the cut below is deliberate.
	localparam [31:0] FILT_MAX_C = `FILT_MAX_CYC;

	// Clamp a programmed count to the longest permitted timeout.
	function [CNT_W-1:0] clamp_cnt;
		input [31:0] v;
		begin
			if (v > FILT_MAX_C) begin
				clamp_cnt = FILT_MAX_C[CNT_W-1:0];
			end else begin
				clamp_cnt = v[CNT_W-1:0];
			end
		end
	endfunction

	// True when the address selects entry i of an indexed group.
	function sel_idx;
		input [7:0] a;
		input [7:0] base;
		input integer i;
		begin
			sel_idx = (a == base + i[7:0]);
		end
	endfunction

	// Register writes.
	integer k;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (k = 0; k < N_DET; k = k + 1) begin
				filt_cfg_r[k] <= {CNT_W{1'b0}};
			end
			for (k = 0; k < N_DUAL; k = k + 1) begin
				edge_cfg_r[k] <= {CNT_W{1'b0}};
			end
			for (k = 0; k < N_OUT; k = k + 1) begin
				oc_cfg_r[k] <= 5'h00;
			end
			dual_digital_r <= {N_DUAL{1'b0}};
			edge_sel_r <= {N_DUAL{1'b0}};
			pulldn_r <= {N_DUAL{1'b0}};
			bus_data_r <= {N_OUT{1'b0}};
			cfg_done_r <= 1'b0;
		end else if (reg_wr) begin
			for (k = 0; k < N_DET; k = k + 1) begin
				if (sel_idx(reg_addr, `A_FILT_BASE, k)) begin
					filt_cfg_r[k] <= clamp_cnt(reg_wdata);
				end
			end
			for (k = 0; k < N_DUAL; k = k + 1) begin
				if (sel_idx(reg_addr, `A_EDGE_BASE, k)) begin
					edge_cfg_r[k] <= clamp_cnt(reg_wdata);
				end
			end
			for (k = 0; k < N_OUT; k = k + 1) begin
				if (sel_idx(reg_addr, `A_OUTCFG_BASE, k)) begin
					oc_cfg_r[k] <= reg_wdata[`OC_DRV_HI:0];
				end
			end
			if (reg_addr == `A_DUAL_MODE) begin
				dual_digital_r <= reg_wdata[N_DUAL-1:0];
			end
			if (reg_addr == `A_EDGE_SEL) begin
				edge_sel_r <= reg_wdata[N_DUAL-1:0];
			end
			if (reg_addr == `A_PULLDN) begin
				pulldn_r <= reg_wdata[N_DUAL-1:0];
			end
			if (reg_addr == `A_BUS_DATA) begin
				bus_data_r <= reg_wdata[N_OUT-1:0];
			end
			if (reg_addr == `A_CFG_DONE) begin
				cfg_done_r <= reg_wdata[0];
			end
		end
	end

	// Register reads; unmapped addresses return zero.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata_r <= 32'h00000000;
		end else if (reg_rd) begin
			reg_rdata_r <= 32'h00000000;
			for (k = 0; k < N_DET; k = k + 1) begin
				if (sel_idx(reg_addr, `A_FILT_BASE, k)) begin
					reg_rdata_r[CNT_W-1:0] <= filt_cfg_r[k];
				end
			end
			for (k = 0; k < N_DUAL; k = k + 1) begin
				if (sel_idx(reg_addr, `A_EDGE_BASE, k)) begin
					reg_rdata_r[CNT_W-1:0] <= edge_cfg_r[k];
				end
			end
			for (k = 0; k < N_OUT; k = k + 1) begin
				if (sel_idx(reg_addr, `A_OUTCFG_BASE, k)) begin
					reg_rdata_r[`OC_DRV_HI:0] <= oc_cfg_r[k];
				end
			end
			case (reg_addr)
				`A_DUAL_MODE: reg_rdata_r[N_DUAL-1:0] <= dual_digital_r;
				`A_EDGE_SEL: reg_rdata_r[N_DUAL-1:0] <= edge_sel_r;
				`A_PULLDN: reg_rdata_r[N_DUAL-1:0] <= pulldn_r;
				`A_BUS_DATA: reg_rdata_r[N_OUT-1:0] <= bus_data_r;
				`A_CFG_DONE: reg_rdata_r[0] <= cfg_done_r;
				`A_DET_STAT: reg_rdata_r[N_DET-1:0] <= det_filtered_r;
				`A_WARN_STAT: reg_rdata_r[N_DUAL-1:0] <= warn_r;
				`A_DIG_STAT: reg_rdata_r[N_DUAL-1:0] <= dig_out_r;
				default: reg_rdata_r[0] <= 1'b0;
			endcase
		end
	end

	// Two-flop synchroniser for the dual-function pins.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_s1_r <= {N_DUAL{1'b0}};
			pin_s2_r <= {N_DUAL{1'b0}};
		end else begin
			pin_s1_r <= dual_function_input_pin;
			pin_s2_r <= pin_s1_r;
		end
	end

	// Filter inputs: analog comparators, or the digital pin for dual inputs in digital mode.
	wire [N_DET-1:0] filt_in;
	wire [N_DET-1:0] filt_out;
	genvar g;
	generate
		for (g = 0; g < N_DET; g = g + 1) begin : g_filt
			reg [CNT_W-1:0] cnt_r;
			reg out_r;
			if (g < N_DET - N_DUAL) begin : g_ded
				assign filt_in[g] = det_raw[g];
			end else begin : g_dual
				assign filt_in[g] = dual_digital_r[g-(N_DET-N_DUAL)] ?
					pin_s2_r[g-(N_DET-N_DUAL)] : det_raw[g];
			end
			// Output changes only after the input has held a new level for the timeout.
			// A count of zero lets a new level through on the first cycle that it is seen.
			always @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					cnt_r <= {CNT_W{1'b0}};
					out_r <= 1'b0;
				end else if (filt_in[g] == out_r) begin
					cnt_r <= {CNT_W{1'b0}};
				end else if (cnt_r >= filt_cfg_r[g]) begin
					out_r <= filt_in[g];
					cnt_r <= {CNT_W{1'b0}};
				end else begin
					cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
				end
			end
			assign filt_out[g] = out_r;
		end
	endgenerate

	// Secondary detectors are supply fault detectors too, so they end in the same glitch filter.
	// Each uses the timeout of its own dual channel.
	wire [N_DUAL-1:0] wfilt_in;
	wire [N_DUAL-1:0] wfilt_out;
	generate
		for (g = 0; g < N_DUAL; g = g + 1) begin : g_wfilt
			reg [CNT_W-1:0] cnt_r;
			reg out_r;
			// Only a dual input in digital mode has a live secondary detector.
			assign wfilt_in[g] = dual_digital_r[g] & det_raw[N_DET-N_DUAL+g];
			// Clearing in analog mode keeps a stale warning from surviving a mode change.
			always @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					cnt_r <= {CNT_W{1'b0}};
					out_r <= 1'b0;
				end else if (!dual_digital_r[g]) begin
					cnt_r <= {CNT_W{1'b0}};
					out_r <= 1'b0;
				end else if (wfilt_in[g] == out_r) begin
					cnt_r <= {CNT_W{1'b0}};
				end else if (cnt_r >= filt_cfg_r[N_DET-N_DUAL+g]) begin
					out_r <= wfilt_in[g];
					cnt_r <= {CNT_W{1'b0}};
				end else begin
					cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
				end
			end
			assign wfilt_out[g] = out_r;
		end
	endgenerate

	// Detector results: a dual input in digital mode reports no analog fault; the analog path is a warning.
	wire [N_DUAL-1:0] warn_nxt;
	assign warn_nxt = dual_digital_r & wfilt_out;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			det_filtered_r <= {N_DET{1'b0}};
			warn_r <= {N_DUAL{1'b0}};
			warn_any_r <= 1'b0;
		end else begin
			det_filtered_r <= filt_out & {~dual_digital_r, {(N_DET-N_DUAL){1'b1}}};
			warn_r <= warn_nxt;
			warn_any_r <= |warn_nxt;
		end
	end

	// Digital blocks: level copy, or a pulse of programmed width on each filtered transition.
	generate
		for (g = 0; g < N_DUAL; g = g + 1) begin : g_dig
			reg prev_r;
			reg [CNT_W-1:0] pw_r;
			wire lvl;
			wire edg;
			assign lvl = filt_out[N_DET-N_DUAL+g];
			assign edg = lvl ^ prev_r;
			always @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					prev_r <= 1'b0;
					pw_r <= {CNT_W{1'b0}};
					dig_out_r[g] <= 1'b0;
				end else begin
					prev_r <= lvl;
					if (!dual_digital_r[g]) begin
						pw_r <= {CNT_W{1'b0}};
						dig_out_r[g] <= 1'b0;
					end else if (!edge_sel_r[g]) begin
						dig_out_r[g] <= lvl;
					end else if (edg) begin
						pw_r <= edge_cfg_r[g];
						dig_out_r[g] <= 1'b1;
					end else if (pw_r > {{(CNT_W-1){1'b0}}, 1'b1}) begin
						pw_r <= pw_r - {{(CNT_W-1){1'b0}}, 1'b1};
					end else begin
						pw_r <= {CNT_W{1'b0}};
						dig_out_r[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// Internal 100 kHz clock from a divider.
	// It free-runs from reset, so a clock-sourced output starts mid-period when it is released.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pclk_cnt_r <= {`PCLK_W{1'b0}};
			pclk_r <= 1'b0;
		end else if (pclk_cnt_r == `PCLK_HALF_CYC - 1) begin
			pclk_cnt_r <= {`PCLK_W{1'b0}};
			pclk_r <= ~pclk_r;
		end else begin
			pclk_cnt_r <= pclk_cnt_r + {{(`PCLK_W-1){1'b0}}, 1'b1};
		end
	end

	// Output source and drive selection; held weakly low until configuration is latched.
	generate
		for (g = 0; g < N_OUT; g = g + 1) begin : g_out
			wire [1:0] src;
			wire [2:0] drv;
			wire [2:0] drv_ok;
			reg data;
			assign src = oc_cfg_r[g][`OC_SRC_HI:`OC_SRC_LO];
			assign drv = oc_cfg_r[g][`OC_DRV_HI:`OC_DRV_LO];
			assign drv_ok = (drv == `DRV_PUMP && g >= `N_PUMP) ? `DRV_OD : drv;
			always @* begin
				case (src)
					`SRC_SEQ: data = seq_drive[g];
					`SRC_BUS: data = bus_data_r[g];
					`SRC_CLK: data = pclk_r;
					default: data = 1'b0;
				endcase
			end
			always @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					driver_output_r[g] <= 1'b0;
					driver_mode_r[g*3+2:g*3] <= `DRV_OD;
					driver_weak_pd_r[g] <= 1'b1;
				end else if (!cfg_done_r) begin
					driver_output_r[g] <= 1'b0;
					driver_mode_r[g*3+2:g*3] <= `DRV_OD;
					driver_weak_pd_r[g] <= 1'b1;
				end else begin
					driver_output_r[g] <= data;
					driver_mode_r[g*3+2:g*3] <= drv_ok;
					driver_weak_pd_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// Pull-down current sources only act on inputs in digital mode.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pulldown_en_r <= {N_DUAL{1'b0}};
		end else begin
			pulldown_en_r <= pulldn_r & dual_digital_r;
		end
	end

endmodule

// [tb/supervisor_properties.sv]
// Port checker for the input filter and output select block.
`timescale 1ns/100ps
`include "supervisor_defines.vh"
module supervisor_properties (
	// Clock, reset and watched ports.
	input wire clk,
	input wire reset_n,
	input wire [9:0] det_raw,
	input wire [9:0] det_filtered_r,
	input wire [4:0] warn_r,
	input wire warn_any_r,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata_r,
	input wire [9:0] driver_output_r,
	input wire [29:0] driver_mode_r,
	input wire [9:0] driver_weak_pd_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// High when an output without a charge pump claims that mode.
	wire pump_bad = driver_mode_r[20:18] == `DRV_PUMP || driver_mode_r[23:21] == `DRV_PUMP
		|| driver_mode_r[26:24] == `DRV_PUMP || driver_mode_r[29:27] == `DRV_PUMP;
	// Bus cycles that start a checked behaviour.
	sequence s_bad_read;
		reg_rd && reg_addr == 8'hFF;
	endsequence
	sequence s_cfg_write;
		reg_wr && reg_addr == `A_CFG_DONE && reg_wdata[0];
	endsequence
	a_warn_or_all: assert property (warn_any_r == |warn_r)
		else $error("warning summary differs from the OR of warnings");
	a_warn_needs_raw: assert property (((warn_r & ~$past(warn_r)) & ~$past(det_raw[9:5], 2)) == 5'h00)
		else $error("warning raised without a comparator result");
	a_unconfig_weak_low: assert property (driver_weak_pd_r[0] |-> driver_output_r == 10'h000
		&& driver_mode_r == 30'h00000000) else $error("unconfigured output not held low");
	a_pump_limit: assert property (!pump_bad)
		else $error("charge pump mode on an output without one");
	a_filter_rise: assert property ($rose(det_filtered_r[0]) |-> $past(det_raw[0], 2))
		else $error("filtered result rose without a lasting input");
	a_unmapped_zero: assert property (s_bad_read |=> reg_rdata_r == 32'h00000000)
		else $error("unmapped read returned nonzero");
	a_rdata_holds: assert property (!$past(reg_rd) |-> $stable(reg_rdata_r))
		else $error("read data changed without a read");
	a_cfg_release: assert property (s_cfg_write |-> ##2 driver_weak_pd_r == 10'h000)
		else $error("outputs not released after configuration load");
endmodule
bind supervisor_input_filter_output_select supervisor_properties u_chk (.clk(clk), .reset_n(reset_n),
	.det_raw(det_raw), .det_filtered_r(det_filtered_r), .warn_r(warn_r), .warn_any_r(warn_any_r),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata_r(reg_rdata_r), .driver_output_r(driver_output_r), .driver_mode_r(driver_mode_r),
	.driver_weak_pd_r(driver_weak_pd_r));

// [tb/supervisor_rail_model.sv]
// Board-side model of the dual-function pins with their weak pull-down.
`timescale 1ns/100ps
module supervisor_rail_model (
	// Clock.
	input wire clk,
	// Board drive and device pull-down.
	input wire [4:0] drive_en,
	input wire [4:0] drive_lvl,
	input wire [4:0] pulldown_en,
	output wire [4:0] pin
);
	reg [4:0] float_r = 5'h00;
	// A floating pin wanders so that its level is never a lucky constant.
	always @(posedge clk) float_r <= ~float_r;
	// Undriven pins read low when the pull-down source is on and follow the wandering level when it is off.
	assign pin = (drive_en & drive_lvl) | (~drive_en & ~pulldown_en & float_r);
endmodule

// [tb/supervisor_input_filter_output_select_tb.sv]
// Self-checking testbench for the input filter and output select block.
`timescale 1ns/100ps
`include "supervisor_defines.vh"
module supervisor_input_filter_output_select_tb;
	reg clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
	reg [9:0] det_raw = 0, seq_drive = 0;
	reg [4:0] pin_en = 0, pin_lvl = 0;
	reg [7:0] reg_addr = 0;
	reg [31:0] reg_wdata = 0;
	wire [4:0] pin, warn_r, dig_out_r, pulldown_en_r;
	wire [9:0] det_filtered_r, driver_output_r, driver_weak_pd_r;
	wire [29:0] driver_mode_r;
	wire [31:0] reg_rdata_r;
	wire warn_any_r;
	integer fails = 0, checked = 0, n;
	reg seen_lvl;
	supervisor_input_filter_output_select DUT (.clk(clk), .reset_n(reset_n), .det_raw(det_raw),
		.dual_function_input_pin(pin), .seq_drive(seq_drive), .det_filtered_r(det_filtered_r),
		.warn_r(warn_r), .warn_any_r(warn_any_r), .dig_out_r(dig_out_r), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
		.driver_output_r(driver_output_r), .driver_mode_r(driver_mode_r),
		.driver_weak_pd_r(driver_weak_pd_r), .pulldown_en_r(pulldown_en_r));
	supervisor_rail_model u_rail (.clk(clk), .drive_en(pin_en), .drive_lvl(pin_lvl),
		.pulldown_en(pulldown_en_r), .pin(pin));
	// Clock at 250 MHz.
	initial begin
		forever #2 clk = ~clk;
	end
	task end_of_test;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task cyc(input integer k);
		repeat (k) @(posedge clk);
	endtask
	// Bus write and read, one strobe cycle each.
	task wr(input [7:0] a, input [31:0] d);
		@(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk) reg_wr <= 0;
	endtask
	task rd(input [7:0] a, input [31:0] e, input string nm);
		@(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clk) reg_rd <= 0;
		#1 chk(nm, e, reg_rdata_r);
	endtask
	task t_reset;
		#1 chk("weak_pd", 10'h3FF, driver_weak_pd_r);
		chk("mode", 0, driver_mode_r);
		rd(8'hFF, 0, "unmapped");
		rd(`A_CFG_DONE, 0, "cfg zero");
	endtask
	// A short pulse is swallowed, a long one comes out late.
	task t_filter;
		wr(`A_FILT_BASE, 10);
		@(posedge clk) det_raw[0] <= 1;
		cyc(5);
		det_raw[0] <= 0;
		cyc(20);
		#1 chk("short pulse", 0, det_filtered_r[0]);
		@(posedge clk) det_raw[0] <= 1;
		cyc(10);
		#1 chk("early", 0, det_filtered_r[0]);
		cyc(3);
		#1 chk("late", 1, det_filtered_r[0]);
		@(posedge clk) det_raw[0] <= 0;
	endtask
	task t_dual;
		wr(`A_DUAL_MODE, 1);
		wr(`A_PULLDN, 1);
		// A warning shorter than its channel's timeout never reaches the status.
		wr(`A_FILT_BASE + 8'h05, 6);
		@(posedge clk) det_raw[5] <= 1;
		cyc(3);
		det_raw[5] <= 0;
		cyc(4);
		#1 chk("warn glitch", 0, warn_r);
		wr(`A_FILT_BASE + 8'h05, 0);
		@(posedge clk) det_raw[5] <= 1;
		cyc(3);
		#1 chk("warn", 1, warn_r);
		chk("warn_any", 1, warn_any_r);
		chk("dual analog", 0, det_filtered_r[5]);
		chk("pulldown", 1, pulldown_en_r);
		rd(`A_WARN_STAT, 1, "warn status");
		@(posedge clk) {pin_en[0], pin_lvl[0]} <= 2'h3;
		cyc(8);
		#1 chk("level", 1, dig_out_r[0]);
		wr(`A_EDGE_BASE, 4);
		wr(`A_EDGE_SEL, 1);
		@(posedge clk) pin_lvl[0] <= 0;
		n = 0;
		repeat (20) begin
			@(posedge clk);
			#1 n += dig_out_r[0];
		end
		chk("pulse width", 4, n);
		@(posedge clk) {pin_en[0], det_raw[5]} <= 0;
	endtask
	task t_out;
		wr(8'h20, 8'h08);
		wr(8'h21, 8'h19);
		wr(8'h26, 8'h1A);
		wr(`A_BUS_DATA, 2);
		seq_drive <= 1;
		cyc(3);
		#1 chk("held", 10'h3FF, driver_weak_pd_r);
		wr(`A_CFG_DONE, 1);
		cyc(1);
		#1 chk("released", 0, driver_weak_pd_r);
		chk("mode", 32'h32, driver_mode_r[5:0]);
		chk("no pump", 0, driver_mode_r[20:18]);
		chk("data", 3, driver_output_r[1:0]);
		// Wait for one toggle of the clock-sourced output, then time the next one, sampling off the edge.
		n = 0;
		seen_lvl = driver_output_r[6];
		while (driver_output_r[6] === seen_lvl && n < 3000) begin
			@(posedge clk) #1 n++;
		end
		n = 0;
		seen_lvl = driver_output_r[6];
		while (driver_output_r[6] === seen_lvl && n < 3000) begin
			@(posedge clk) #1 n++;
		end
		chk("clock half", `PCLK_HALF_CYC, n);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1;
		t_reset;
		t_filter;
		t_dual;
		t_out;
		end_of_test;
	end
	// Watchdog well past the expected run.
	initial begin
		cyc(20000);
		fails++;
		end_of_test;
	end
endmodule
